//--- include/gtc_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants, register map and types of the gated timer counter
package gtc_pkg;

  // apb geometry
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFF_GATE_CTRL = 8'h04;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h0c;
  localparam logic [7:0] OFF_OSC_STATUS = 8'h10;
  localparam logic [7:0] OFF_INT_STATUS = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;

  // counter and prescaler widths
  localparam int COUNT_W = 16;
  localparam int PRESCALE_W = 3;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // reset values
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
  localparam logic [7:0] GATE_CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  // interrupt status and mask layout
  localparam int INT_W = 2;
  localparam int INT_OVERFLOW_BIT = 0;
  localparam int INT_OSC_READY_BIT = 1;

  // oscillator status layout
  localparam int OSC_READY_BIT = 0;

  // secondary oscillator cycles counted before ready
  localparam int OSC_READY_CYCLES = 1024;

  // core clocks per instruction cycle
  localparam int INSTR_PHASES = 4;

  // positions in the synchronised pin vector
  localparam int PIN_EXT_CLK = 0;
  localparam int PIN_GATE = 1;
  localparam int PIN_SEC_OSC = 2;
  localparam int PIN_COMP_ONE = 3;
  localparam int PIN_COMP_TWO = 4;
  localparam int PIN_W = 5;

  // count clock sources
  typedef enum logic [1:0] {SRC_INSTR, SRC_CORE, SRC_EXTERNAL, SRC_SPARE} gtc_clk_src_e;

  // gate sources
  typedef enum logic [1:0] {
    GATE_PIN, GATE_BYTE_TIMER, GATE_COMP_ONE, GATE_COMP_TWO
  } gtc_gate_src_e;

  // timer control register layout
  typedef struct packed {
    gtc_clk_src_e clockSource;
    logic [1:0] prescaleSelect;
    logic secOscEnable;
    logic syncDisableBit;
    logic spare;
    logic timerOn;
  } gtc_timer_ctrl_s;

  // gate control register layout, gateLevel is read only
  typedef struct packed {
    logic gateEnable;
    logic gatePolarity;
    logic [2:0] spare;
    logic gateLevel;
    gtc_gate_src_e gateSourceSelect;
  } gtc_gate_ctrl_s;

endpackage

//--- rtl/gtc_osc_ready.sv
////////////////////////////////////////////////////////////////////////////////
// secondary oscillator start-up watch: ready after a fixed number of cycles
module gtc_osc_ready
  import gtc_pkg::*;
#(
  parameter int READY_CYCLES = OSC_READY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic oscEnable,
  input wire logic oscEdge,
  output logic ready
);

  localparam int CNT_W = $clog2(READY_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST_CYCLE = CNT_W'(READY_CYCLES - 1);

  logic [CNT_W-1:0] cycleCnt_reg; // oscillator cycles seen since enable
  logic [CNT_W-1:0] cycleCnt_next;
  logic enPrev_reg; // enable of the previous cycle
  logic ready_reg; // oscillator judged stable
  logic ready_next;

  ////////////////////////////////////////////////////////////////////////////////
  // next state of the start-up counter
  always_comb begin
    cycleCnt_next = cycleCnt_reg;
    ready_next = ready_reg;
    // RULE5 enable clears ready
    if (!oscEnable || !enPrev_reg) begin
      cycleCnt_next = '0;
      ready_next = 1'b0;
    end else if (!ready_reg && oscEdge) begin
      // RULE5 count oscillator cycles
      cycleCnt_next = CNT_W'(cycleCnt_reg + 1'b1);
      ready_next = (cycleCnt_reg == LAST_CYCLE);
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycleCnt_reg <= '0;
      enPrev_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      cycleCnt_reg <= cycleCnt_next;
      enPrev_reg <= oscEnable;
      ready_reg <= ready_next;
    end
  end

  assign ready = ready_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_enable_rise;
    oscEnable && !enPrev_reg;
  endsequence

  a_osc_ready_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    s_enable_rise |=> !ready_reg)
    else $error("ready not cleared when oscillator enabled");

  a_osc_ready_count: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    $rose(ready_reg) |-> $past(cycleCnt_reg) == LAST_CYCLE && $past(oscEdge))
    else $error("ready set before the oscillator cycle count");

endmodule

//--- rtl/gtc_timer.sv
////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - prescaler divides by 1, 2, 4 or 8
// RULE2 - count byte write clears hidden prescaler
// RULE3 - 16-bit count read as two bytes
// RULE4 - oscillator enable starts crystal, survives sleep
// RULE5 - enable clears ready, 1024 cycles set it
// RULE6 - sync disable: external clock counted unsynchronised
// RULE7 - async external counting runs in sleep, wakes
// RULE8 - mode switch may lose or add increment
// RULE9 - byte reads valid under external clock
// RULE10 - software stops counter before writing count
// RULE11 - no gating means free counting
// RULE12 - gated: count only when gate equals polarity
// RULE13 - two-bit field picks one of four gates
// RULE14 - one polarity bit serves every gate source
// RULE15 - all-ones wraps to zero, sets overflow flag
//
// Added by the designer: register access over APB and the register offsets.
module gtc_timer
  import gtc_pkg::*;
#(
  parameter int READY_CYCLES = OSC_READY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counterClockPin,
  input wire logic gatePin,
  input wire logic secOscInPin,
  input wire logic byteTimerOverflow,
  input wire logic comparatorOneOut,
  input wire logic comparatorTwoOut,
  input wire logic sleepMode,
  output logic secOscOutPin,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // terminal prescaler value for a divide select
  function automatic logic [PRESCALE_W-1:0] prescaleLimit(input logic [1:0] sel);
    prescaleLimit = PRESCALE_W'((1 << sel) - 1);
  endfunction

  // true for an offset that holds a register
  function automatic logic isMapped(input logic [APB_ADDR_W-1:0] addr);
    isMapped = (addr == OFF_TIMER_CTRL) || (addr == OFF_GATE_CTRL) ||
               (addr == OFF_COUNT_LOW) || (addr == OFF_COUNT_HIGH) ||
               (addr == OFF_OSC_STATUS) || (addr == OFF_INT_STATUS) ||
               (addr == OFF_INT_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [PIN_W-1:0] syncA_reg; // first synchroniser stage
  logic [PIN_W-1:0] syncB_reg; // second synchroniser stage
  logic [PIN_W-1:0] syncC_reg; // history for edge detection
  logic [PIN_W-1:0] pinVec; // raw pins gathered
  logic extRise; // rising edge of the external clock pin
  logic oscRise; // rising edge of the crystal
  logic extDly_reg; // synchronous-mode tick delayed one stage
  logic extDly_next;
  logic [1:0] phase_reg; // instruction phase counter
  logic [1:0] phase_next;
  logic instrTick; // one core clock per instruction cycle
  gtc_timer_ctrl_s ctrl_reg; // timer control register
  gtc_timer_ctrl_s ctrl_next;
  gtc_gate_ctrl_s gate_reg; // gate control register
  gtc_gate_ctrl_s gate_next;
  logic [COUNT_W-1:0] count_reg; // the count
  logic [COUNT_W-1:0] count_next;
  logic [PRESCALE_W-1:0] prescale_reg; // hidden prescale counter
  logic [PRESCALE_W-1:0] prescale_next;
  logic [INT_W-1:0] intStatus_reg; // sticky event flags
  logic [INT_W-1:0] intStatus_next;
  logic [INT_W-1:0] intMask_reg; // event enables
  logic [INT_W-1:0] intMask_next;
  logic [INT_W-1:0] intSet; // events of this cycle
  logic extTickRaw; // external source edge before mode path
  logic srcTick; // selected source tick
  logic gateLevel; // selected gate before polarity
  logic gateOk; // gate lets counting proceed
  logic countTick; // gated tick into the prescaler
  logic countIncr; // prescaled increment of the count
  logic countWrite; // software writes a count byte
  logic wrLow; // write of the low byte
  logic wrHigh; // write of the high byte
  logic oscReady; // crystal stable
  logic oscReadyPrev_reg; // ready of the previous cycle
  logic apbSetup; // access phase before the answer
  logic apbDone; // access completes this edge
  logic apbWrite; // write takes effect this edge
  logic [7:0] readByte; // selected read data
  logic [APB_DATA_W-1:0] prdata_reg;
  logic [APB_DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic irq_reg;
  logic irq_next;
  logic secOscOut_reg; // amplifier output towards the crystal
  logic secOscOut_next;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two stages before any logic

  // gather pins
  always_comb begin
    pinVec = '0;
    pinVec[PIN_EXT_CLK] = counterClockPin;
    pinVec[PIN_GATE] = gatePin;
    pinVec[PIN_SEC_OSC] = secOscInPin;
    pinVec[PIN_COMP_ONE] = comparatorOneOut;
    pinVec[PIN_COMP_TWO] = comparatorTwoOut;
  end

  // synchroniser and edge history stages
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      syncC_reg <= '0;
    end else begin
      syncA_reg <= pinVec;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  assign extRise = syncB_reg[PIN_EXT_CLK] && !syncC_reg[PIN_EXT_CLK];
  assign oscRise = syncB_reg[PIN_SEC_OSC] && !syncC_reg[PIN_SEC_OSC];

  ////////////////////////////////////////////////////////////////////////////////
  // count source selection

  // source tick and gate
  always_comb begin
    // RULE4 crystal replaces the pin when enabled
    extTickRaw = ctrl_reg.secOscEnable ? oscRise : extRise;
    // synchronous mode counts through one more stage
    extDly_next = extTickRaw && !ctrl_reg.syncDisableBit && !sleepMode;
    phase_next = phase_reg + 2'h1;
    unique case (ctrl_reg.clockSource)
      SRC_INSTR: srcTick = instrTick && !sleepMode;
      SRC_CORE: srcTick = !sleepMode;
      // RULE6 unsynchronised path when sync disabled
      // RULE7 async external keeps counting in sleep
      // RULE8 path change may drop the staged tick, never repeat it
      SRC_EXTERNAL: srcTick = ctrl_reg.syncDisableBit ? extTickRaw : extDly_reg;
      SRC_SPARE: srcTick = 1'b0;
    endcase
    // RULE13 gate source mux
    unique case (gate_reg.gateSourceSelect)
      GATE_PIN: gateLevel = syncB_reg[PIN_GATE];
      GATE_BYTE_TIMER: gateLevel = byteTimerOverflow;
      GATE_COMP_ONE: gateLevel = syncB_reg[PIN_COMP_ONE];
      GATE_COMP_TWO: gateLevel = syncB_reg[PIN_COMP_TWO];
    endcase
    // RULE11 free running without gating
    // RULE12 gate enables or holds
    // RULE14 one polarity for all sources
    gateOk = !gate_reg.gateEnable || (gateLevel == gate_reg.gatePolarity);
    countTick = ctrl_reg.timerOn && gateOk && srcTick;
  end

  assign instrTick = (phase_reg == 2'(INSTR_PHASES - 1));

  // source registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extDly_reg <= 1'b0;
      phase_reg <= 2'h0;
    end else begin
      extDly_reg <= extDly_next;
      phase_reg <= phase_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler, count and events

  // next values of the counting path
  always_comb begin
    prescale_next = prescale_reg;
    countIncr = 1'b0;
    count_next = count_reg;
    intSet = '0;
    // RULE1 divide by the selected ratio
    if (countTick) begin
      if (prescale_reg >= prescaleLimit(ctrl_reg.prescaleSelect)) begin
        prescale_next = '0;
        countIncr = 1'b1;
      end else begin
        prescale_next = PRESCALE_W'(prescale_reg + 1'b1);
      end
    end
    // RULE2 count byte write clears prescaler
    if (countWrite) begin
      prescale_next = '0;
    end
    // RULE10 a write simply wins over a coinciding increment
    if (wrLow) begin
      count_next = {count_reg[15:8], pwdata[7:0]};
    end else if (wrHigh) begin
      count_next = {pwdata[7:0], count_reg[7:0]};
    end else if (countIncr) begin
      // RULE15 wrap and flag overflow
      count_next = count_reg + 16'h0001;
      intSet[INT_OVERFLOW_BIT] = (count_reg == COUNT_MAX);
    end
    intSet[INT_OSC_READY_BIT] = oscReady && !oscReadyPrev_reg;
  end

  // counting registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_reg <= '0;
      count_reg <= COUNT_RESET;
      oscReadyPrev_reg <= 1'b0;
    end else begin
      prescale_reg <= prescale_next;
      count_reg <= count_next;
      oscReadyPrev_reg <= oscReady;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // secondary oscillator

  // RULE5 start-up watch
  gtc_osc_ready #(
    .READY_CYCLES(READY_CYCLES)
  ) u_osc_ready (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .oscEnable(ctrl_reg.secOscEnable),
    .oscEdge(oscRise),
    .ready(oscReady)
  );

  // RULE4 amplifier runs while enabled, sleep or not
  always_comb begin
    secOscOut_next = ctrl_reg.secOscEnable && !syncB_reg[PIN_SEC_OSC];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  // bus decode and register next values
  always_comb begin
    apbSetup = psel && penable && !pready_reg;
    apbDone = psel && penable && pready_reg;
    apbWrite = apbDone && pwrite;
    wrLow = apbWrite && (paddr == OFF_COUNT_LOW);
    wrHigh = apbWrite && (paddr == OFF_COUNT_HIGH);
    countWrite = wrLow || wrHigh;
    ctrl_next = ctrl_reg;
    gate_next = gate_reg;
    intMask_next = intMask_reg;
    if (apbWrite && (paddr == OFF_TIMER_CTRL)) begin
      ctrl_next = gtc_timer_ctrl_s'(pwdata[7:0]);
      ctrl_next.spare = 1'b0;
    end
    if (apbWrite && (paddr == OFF_GATE_CTRL)) begin
      gate_next = gtc_gate_ctrl_s'(pwdata[7:0]);
      gate_next.spare = 3'h0;
      gate_next.gateLevel = 1'b0;
    end
    if (apbWrite && (paddr == OFF_INT_MASK)) begin
      intMask_next = pwdata[INT_W-1:0];
    end
    // write one to clear, a new event wins
    intStatus_next = intStatus_reg;
    if (apbWrite && (paddr == OFF_INT_STATUS)) begin
      intStatus_next = intStatus_reg & ~pwdata[INT_W-1:0];
    end
    intStatus_next = intStatus_next | intSet;
    // RULE3 count read byte by byte
    // RULE9 count sampled in the core domain, always whole
    readByte = 8'h00;
    if (paddr == OFF_TIMER_CTRL) begin
      readByte = ctrl_reg;
    end else if (paddr == OFF_GATE_CTRL) begin
      readByte = {gate_reg.gateEnable, gate_reg.gatePolarity, 3'h0, gateLevel,
                  gate_reg.gateSourceSelect};
    end else if (paddr == OFF_COUNT_LOW) begin
      readByte = count_reg[7:0];
    end else if (paddr == OFF_COUNT_HIGH) begin
      readByte = count_reg[15:8];
    end else if (paddr == OFF_OSC_STATUS) begin
      readByte[OSC_READY_BIT] = oscReady;
    end else if (paddr == OFF_INT_STATUS) begin
      readByte[INT_W-1:0] = intStatus_reg;
    end else if (paddr == OFF_INT_MASK) begin
      readByte[INT_W-1:0] = intMask_reg;
    end
    pready_next = apbSetup;
    pslverr_next = apbSetup && !isMapped(paddr);
    prdata_next = (apbSetup && !pwrite) ? {24'h00_0000, readByte} : '0;
    // RULE7 overflow interrupt can wake the core
    irq_next = |(intStatus_next & intMask_next);
  end

  // register file and bus outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= gtc_timer_ctrl_s'(TIMER_CTRL_RESET);
      gate_reg <= gtc_gate_ctrl_s'(GATE_CTRL_RESET);
      intStatus_reg <= '0;
      intMask_reg <= INT_MASK_RESET;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      secOscOut_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      gate_reg <= gate_next;
      intStatus_reg <= intStatus_next;
      intMask_reg <= intMask_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      secOscOut_reg <= secOscOut_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign secOscOutPin = secOscOut_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_prescale_ratio: assert property ( // RULE1
    countIncr |-> prescale_reg >= prescaleLimit(ctrl_reg.prescaleSelect))
    else $error("increment before prescaler terminal value");

  a_prescale_clear: assert property ( // RULE2
    countWrite |=> prescale_reg == '0)
    else $error("prescaler not cleared by count write");

  a_read_high: assert property ( // RULE3
    apbSetup && !pwrite && paddr == OFF_COUNT_HIGH |=>
      pready_reg && prdata_reg[7:0] == $past(count_reg[15:8]))
    else $error("high byte read wrong");

  a_osc_out_sleep: assert property ( // RULE4
    ctrl_reg.secOscEnable && sleepMode |=> secOscOutPin == !$past(syncB_reg[PIN_SEC_OSC]))
    else $error("oscillator amplifier stopped");

  a_async_direct: assert property ( // RULE6
    ctrl_reg.syncDisableBit && ctrl_reg.clockSource == SRC_EXTERNAL && ctrl_reg.timerOn &&
      !gate_reg.gateEnable && extTickRaw |-> countTick)
    else $error("asynchronous edge not counted at once");

  a_sleep_count: assert property ( // RULE7
    sleepMode && countIncr && !countWrite |=> count_reg != $past(count_reg))
    else $error("count stalled in sleep");

  a_wake_irq: assert property ( // RULE7
    intStatus_reg[INT_OVERFLOW_BIT] && intMask_reg[INT_OVERFLOW_BIT] |-> irq_reg)
    else $error("unmasked overflow without interrupt");

  a_free_count: assert property ( // RULE11
    ctrl_reg.timerOn && !gate_reg.gateEnable && srcTick && ctrl_reg.prescaleSelect == 2'h0 &&
      !countWrite |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("free count missed an increment");

  a_gate_hold: assert property ( // RULE12
    gate_reg.gateEnable && gateLevel != gate_reg.gatePolarity && !countWrite |=>
      $stable(count_reg))
    else $error("count moved while gate closed");

  a_gate_source: assert property ( // RULE13 RULE14
    gate_reg.gateEnable && gate_reg.gateSourceSelect == GATE_BYTE_TIMER &&
      byteTimerOverflow != gate_reg.gatePolarity |-> !countTick)
    else $error("byte timer gate ignored");

  a_overflow_wrap: assert property ( // RULE15
    countIncr && count_reg == COUNT_MAX && !countWrite |=>
      count_reg == COUNT_RESET && intStatus_reg[INT_OVERFLOW_BIT] ##1 irq_reg ||
      !intMask_reg[INT_OVERFLOW_BIT])
    else $error("overflow did not wrap and flag");

endmodule

//--- verification/gtc_src_model.sv
////////////////////////////////////////////////////////////////////////////////
// far side: external count clock and the watch crystal
module gtc_src_model (
  input wire logic core_clk,
  input wire logic oscRun,
  output logic extClk,
  output logic crystal
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines idle low at start
  initial begin
    extClk = 1'b0;
    crystal = 1'b0;
  end
  // n full pulses on the count pin, then the line stands still low
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      extClk <= 1'b1;
      repeat (4) @(posedge core_clk);
      extClk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
  endtask
  always begin
    repeat (4) @(posedge core_clk);
    crystal <= oscRun ? ~crystal : 1'b0;
  end
endmodule

//--- verification/gtc_timer_tb.sv
////////////////////////////////////////////////////////////////////////////////
// bench: apb sequences against the gated timer counter
module gtc_timer_tb
  import gtc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = 8'h00;
  logic [APB_DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [APB_DATA_W-1:0] prdata;
  logic [APB_DATA_W-1:0] rdata; // last read word
  logic pready;
  logic pslverr;
  logic busErr; // error flag of last transfer
  logic gatePin = 1'b0;
  logic byteTimerOverflow = 1'b0;
  logic comparatorOneOut = 1'b0;
  logic comparatorTwoOut = 1'b0;
  logic sleepMode = 1'b0;
  logic oscRun = 1'b0; // lets the crystal swing
  logic extClk;
  logic crystal;
  logic secOscOutPin;
  logic irq;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  // small ready count keeps the start-up wait short
  gtc_timer #(.READY_CYCLES(4)) u_gtc_timer (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counterClockPin(extClk),
    .gatePin(gatePin), .secOscInPin(crystal), .byteTimerOverflow(byteTimerOverflow),
    .comparatorOneOut(comparatorOneOut), .comparatorTwoOut(comparatorTwoOut),
    .sleepMode(sleepMode), .secOscOutPin(secOscOutPin), .irq(irq)
  );
  gtc_src_model u_gtc_src_model (
    .core_clk(core_clk), .oscRun(oscRun), .extClk(extClk), .crystal(crystal)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // closing report, reached from the main sequence or the hang guard
  task automatic summarize();
    $display("counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // single comparison point
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdata = prdata;
    busErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdata, {24'h00_0000, e});
  endtask
  // stop, clear the count, restart with ctrl, send n edges, read the low byte
  task automatic run(input logic [7:0] ctrl, input int n, input logic [7:0] e);
    wr(OFF_TIMER_CTRL, 8'h00);
    wr(OFF_COUNT_LOW, 8'h00);
    wr(OFF_COUNT_HIGH, 8'h00);
    wr(OFF_TIMER_CTRL, ctrl);
    u_gtc_src_model.pulse(n);
    rd(OFF_COUNT_LOW, e);
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped word
    for (int a = 0; a < 28; a += 4) begin
      rd(8'(a), 8'h00);
    end
    rd(8'h1c, 8'h00);
    chk({31'h0000_0000, busErr}, 32'h0000_0001);
    $display("test reset done");
    // each divide ratio on 16 async external edges, no gating
    for (int i = 0; i < 4; i++) begin
      run({2'h2, 2'(i), 4'h5}, 16, 8'(16 >> i));
    end
    // 5 edges into divide by 8, count write, 3 more edges: still zero
    run(8'hb5, 5, 8'h00);
    wr(OFF_TIMER_CTRL, 8'h00);
    wr(OFF_COUNT_LOW, 8'h00);
    wr(OFF_TIMER_CTRL, 8'hb5);
    u_gtc_src_model.pulse(3);
    rd(OFF_COUNT_LOW, 8'h00);
    $display("test prescaler done");
    // every gate source at both polarities, selected source high
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        gatePin <= (s == 0);
        byteTimerOverflow <= (s == 1);
        comparatorOneOut <= (s == 2);
        comparatorTwoOut <= (s == 3);
        wr(OFF_GATE_CTRL, {1'b1, 1'(p), 4'h0, 2'(s)});
        rd(OFF_GATE_CTRL, {1'b1, 1'(p), 4'h1, 2'(s)});
        run(8'h85, 4, (p == 1) ? 8'h04 : 8'h00);
      end
    end
    wr(OFF_GATE_CTRL, 8'h00);
    $display("test gate done");
    // asleep: async external counts, synchronised mode holds
    sleepMode <= 1'b1;
    run(8'h85, 3, 8'h03);
    run(8'h81, 3, 8'h00);
    // internal sources stand still while asleep
    run(8'h41, 0, 8'h00);
    run(8'h01, 0, 8'h00);
    sleepMode <= 1'b0;
    run(8'h81, 3, 8'h03);
    // core source: ten increments before the read is taken, spare source idle
    run(8'h41, 0, 8'h0a);
    run(8'hc1, 0, 8'h00);
    $display("test sleep done");
    // wrap from all ones, sticky flag, mask and clear
    wr(OFF_TIMER_CTRL, 8'h00);
    wr(OFF_INT_MASK, 8'h01);
    wr(OFF_COUNT_LOW, 8'hff);
    wr(OFF_COUNT_HIGH, 8'hff);
    rd(OFF_COUNT_HIGH, 8'hff);
    rd(OFF_COUNT_LOW, 8'hff);
    wr(OFF_TIMER_CTRL, 8'h85);
    u_gtc_src_model.pulse(1);
    rd(OFF_COUNT_LOW, 8'h00);
    rd(OFF_COUNT_HIGH, 8'h00);
    rd(OFF_INT_STATUS, 8'h01);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(OFF_INT_MASK, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(OFF_INT_MASK, 8'h01);
    wr(OFF_INT_STATUS, 8'h01);
    repeat (2) @(posedge core_clk);
    rd(OFF_INT_STATUS, 8'h00);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test overflow done");
    // crystal start-up: ready only after 4 crystal cycles, kept in sleep
    oscRun <= 1'b1;
    wr(OFF_TIMER_CTRL, 8'h08);
    rd(OFF_OSC_STATUS, 8'h00);
    // 15 periods of 8 core cycles, well above the 4 needed plus synchroniser margin
    repeat (120) @(posedge core_clk);
    rd(OFF_OSC_STATUS, 8'h01);
    rd(OFF_INT_STATUS, 8'h02);
    sleepMode <= 1'b1;
    repeat (40) @(posedge core_clk);
    rd(OFF_OSC_STATUS, 8'h01);
    // amplifier drives the inverse of the crystal, three edges late
    @(negedge crystal);
    repeat (4) @(posedge core_clk);
    chk({31'h0000_0000, secOscOutPin}, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    chk({31'h0000_0000, secOscOutPin}, 32'h0000_0000);
    wr(OFF_TIMER_CTRL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({31'h0000_0000, secOscOutPin}, 32'h0000_0000);
    wr(OFF_TIMER_CTRL, 8'h08);
    rd(OFF_OSC_STATUS, 8'h00);
    sleepMode <= 1'b0;
    $display("test oscillator done");
    summarize();
  end
endmodule
